// ===== rtl/bss_pkg.sv
package bss_pkg;
   // ---------------------------------------------------------------
   // timebase
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int TICK_NS = 1000;                   // 1 us tick period
   localparam int TICK_DIV = TICK_NS * CLK_MHZ / 1000;

   // ---------------------------------------------------------------
   // times in microseconds (tick counts)
   // ---------------------------------------------------------------
   localparam int DETECT_DELAY_US = 100;
   localparam int DETECT_LOW_US = 260;
   localparam int DETECT_WINDOW_US = 1000;
   localparam int EN_OFF_US = 2500;
   localparam int DIM_OFF_US = 20000;
   localparam int REDUCED_LIMIT_US = 5000;
   localparam int BIT_MIN_US = 2;
   localparam int BIT_HALF_MAX_US = 180;
   localparam int STREAM_END_US = 360;
   localparam int ACK_VALID_US = 2;
   localparam int ACK_DURATION_US = 512;
   localparam int ACK_HOLD_US = 256;
   localparam int SOFT_RAMP_US = 1000;

   // ---------------------------------------------------------------
   // one-wire stream layout
   // ---------------------------------------------------------------
   localparam int CODE_W = 9;
   localparam logic [8:0] CODE_RESET = 9'h1ff;
   localparam int FRAME_W = 16;
   localparam int ACK_BIT_POS = 15;
   localparam int CNT_W = 16;
   localparam int NCH = 2;

   // ---------------------------------------------------------------
   // sequencer states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      BSS_OFF, BSS_DETECT, BSS_CHECK, BSS_ABORT, BSS_RUN
   } bss_state_e;
endpackage

// ===== rtl/bss_low_timer.sv
`timescale 1ns/1ps
// counts ticks while a level is low; flags once past a limit
module bss_low_timer #(
   parameter int LIMIT = 2500
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic tick_i,
   input wire logic level_i,
   output logic expired_o
);
   typedef struct packed {
      logic [15:0] cnt;
      logic expired;
   } bss_lt_s;
   bss_lt_s r, next_r;

   // ---------------------------------------------------------------
   // counter
   // ---------------------------------------------------------------
   // a high level restarts the count, so glitch-free pulses keep it 0
   always_comb begin
      next_r = r;
      if (level_i) begin
         next_r.cnt = '0;
         next_r.expired = 1'b0;
      end else if (tick_i && !r.expired) begin
         next_r.cnt = r.cnt + 16'h0001;
         if (r.cnt >= 16'(LIMIT)) begin
            next_r.expired = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign expired_o = r.expired;
endmodule

// ===== rtl/bss_sequencer.sv
`timescale 1ns/1ps
// Summary of operation
// RULE1: leave shutdown only with supply good, enable high, dimming high.
// RULE2: detection window picks one-wire on pattern, else PWM interface.
// RULE3: host waits 100us, holds enable low over 260us within 1ms.
// RULE4: at window end, grounded sink feedback pins disable their channel.
// RULE5: both sink pins grounded aborts start-up; no switching ever.
// RULE6: soft start and switching begin only after channel detection.
// RULE7: enable low over 2.5ms or dimming low over 20ms shuts down.
// RULE8: first 5ms of switching uses startup current limit, then normal.
// RULE9: host gives at least 2us start period before each stream.
// RULE10: host holds end-of-stream 2us to 360us after last bit.
// RULE11: zero bit: high 2-180us, low at least twice that, max 360us.
// RULE12: one bit: low 2-180us, high at least twice that, max 360us.
// RULE13: active-low acknowledge only when request_ack_bit set; host pulls up.
// RULE14: acknowledge low valid within 2us, released within 512us.
// RULE15: 9-bit brightness code resets to all ones on shutdown.
// RULE16: interface selection repeats at every start-up from shutdown.
// RULE17: pin phases measured by tick counters; bits by phase comparison.
// RULE18: shutdown clears selection, channel enables and soft-start timer.
module bss_sequencer #(
   parameter int EN_OFF_TICKS = bss_pkg::EN_OFF_US,
   parameter int DIM_OFF_TICKS = bss_pkg::DIM_OFF_US,
   parameter int LIMIT_TICKS = bss_pkg::REDUCED_LIMIT_US,
   // clock cycles per timebase tick; shortened only to speed up runs
   parameter int TICK_CYCLES = bss_pkg::TICK_DIV
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic supply_good_i,
   input wire logic enable_pin_i,
   input wire logic dimming_pin_i,
   input wire logic [bss_pkg::NCH-1:0] sink_feedback_pin_i,
   input wire logic enable_pin_ack_i,
   output logic enable_pin_ack_o,
   output logic enable_pin_ack_oe_o,
   output logic active_o,
   output logic one_wire_sel_o,
   output logic [bss_pkg::NCH-1:0] channel_en_o,
   output logic switching_o,
   output logic startup_current_limit_o,
   output logic [7:0] comp_ramp_o,
   output logic [bss_pkg::CODE_W-1:0] brightness_code_o,
   output logic code_update_o
);
   import bss_pkg::*;

   typedef struct packed {
      logic [1:0] sup_s1, en_s1, dim_s1;
      logic [1:0] sup_s2, en_s2, dim_s2;
      logic [NCH-1:0] fb_s1, fb_s2;
      logic [6:0] div;
      logic tick;
      bss_state_e state;
      logic [CNT_W-1:0] t;
      logic [CNT_W-1:0] low_t;
      logic one_wire;
      logic [NCH-1:0] ch_en;
      logic [CNT_W-1:0] ss_t;
      logic [7:0] ramp;
      logic en_d;
      logic [CNT_W-1:0] hi_t, lo_t;
      logic [FRAME_W-1:0] shreg;
      logic [4:0] nbits;
      logic [CODE_W-1:0] code;
      logic upd;
      logic [CNT_W-1:0] ack_t;
      logic ack;
   } bss_s;
   bss_s r, next_r;

   logic rst_n;
   logic en_q, dim_q, sup_q, en_rise, en_fall, en_expired, dim_expired;
   logic [NCH-1:0] fb_q;

   // ---------------------------------------------------------------
   // reset release and synchronised pins
   // ---------------------------------------------------------------
   // reset synchroniser kept outside the struct: it drives the others
   logic [1:0] rst_pipe;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_pipe <= 2'b00;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe[1];

   assign en_q = r.en_s2[0];
   assign dim_q = r.dim_s2[0];
   assign sup_q = r.sup_s2[0];
   assign fb_q = r.fb_s2;
   assign en_rise = en_q && !r.en_d;
   assign en_fall = !en_q && r.en_d;

   // ---------------------------------------------------------------
   // shutdown low timers
   // ---------------------------------------------------------------
   bss_low_timer #(.LIMIT(EN_OFF_TICKS)) u_en_off (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .tick_i(r.tick),
      .level_i(en_q),
      .expired_o(en_expired)
   );
   bss_low_timer #(.LIMIT(DIM_OFF_TICKS)) u_dim_off (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .tick_i(r.tick),
      .level_i(dim_q),
      .expired_o(dim_expired)
   );

   // ---------------------------------------------------------------
   // sequencer, one-wire decoder, acknowledge
   // ---------------------------------------------------------------
   always_comb begin
      next_r = r;
      // first stage only feeds second stage
      next_r.sup_s1 = {1'b0, supply_good_i};
      next_r.en_s1 = {1'b0, enable_pin_i};
      next_r.dim_s1 = {1'b0, dimming_pin_i};
      next_r.fb_s1 = sink_feedback_pin_i;
      next_r.sup_s2 = r.sup_s1;
      next_r.en_s2 = r.en_s1;
      next_r.dim_s2 = r.dim_s1;
      next_r.fb_s2 = r.fb_s1;
      next_r.en_d = en_q;
      next_r.upd = 1'b0;
      // 1 us tick from the 100 MHz clock
      next_r.tick = (r.div == 7'(TICK_CYCLES - 1));
      next_r.div = next_r.tick ? 7'h00 : r.div + 7'h01; // RULE17
      if (r.tick && r.t != '1) begin
         next_r.t = r.t + 16'h0001;
      end
      unique case (r.state)
         BSS_OFF: begin
            // all three start conditions together
            if (sup_q && en_q && dim_q) begin // RULE1
               next_r.state = BSS_DETECT;
               next_r.t = '0;
               next_r.low_t = '0;
            end
         end
         BSS_DETECT: begin
            // pattern: low run after the delay, done before window end
            if (!en_q && r.t >= 16'(DETECT_DELAY_US)) begin // RULE3
               if (r.tick) begin
                  next_r.low_t = r.low_t + 16'h0001;
               end
            end else if (en_q && r.low_t > 16'(DETECT_LOW_US)) begin
               next_r.one_wire = 1'b1; // RULE2
            end else if (en_q) begin
               next_r.low_t = '0;
            end
            if (r.t >= 16'(DETECT_WINDOW_US)) begin
               next_r.state = BSS_CHECK; // RULE2
            end
         end
         BSS_CHECK: begin
            // grounded feedback pin (reads 0) drops the channel
            next_r.ch_en = fb_q; // RULE4
            next_r.ss_t = '0;
            next_r.ramp = '0;
            next_r.state = (fb_q == '0) ? BSS_ABORT : BSS_RUN; // RULE5
         end
         BSS_ABORT: begin
            // parked until shutdown; no switching from here
            next_r.state = BSS_ABORT; // RULE5
         end
         BSS_RUN: begin
            // soft start follows channel detection
            if (r.tick && r.ss_t != '1) begin // RULE6
               next_r.ss_t = r.ss_t + 16'h0001;
               if (r.ss_t < 16'(SOFT_RAMP_US) && r.ss_t[1:0] == 2'b11) begin
                  next_r.ramp = (r.ramp == 8'hff) ? r.ramp : r.ramp + 8'h01;
               end
            end
         end
      endcase
      // one-wire bit decoder: phases measured, then compared
      if (r.one_wire && r.state == BSS_RUN) begin
         if (en_q && r.tick && r.hi_t != '1) begin
            next_r.hi_t = r.hi_t + 16'h0001; // RULE17
         end
         if (!en_q && r.tick && r.lo_t != '1) begin
            next_r.lo_t = r.lo_t + 16'h0001;
         end
         if (en_rise && r.hi_t != '0) begin
            // bit ends on low-to-high edge: high came first
            // short phase up to 180 us, long phase up to 360 us
            if (r.hi_t <= 16'(STREAM_END_US) &&
                r.lo_t <= 16'(STREAM_END_US) &&
                (r.hi_t <= 16'(BIT_HALF_MAX_US) ||
                 r.lo_t <= 16'(BIT_HALF_MAX_US))) begin
               next_r.shreg = {r.shreg[FRAME_W-2:0],
                               (r.hi_t > r.lo_t)}; // RULE11 RULE12
               next_r.nbits = r.nbits + 5'h01;
            end else begin
               // malformed bit: drop the stream rather than misalign it
               next_r.nbits = '0;
            end
            next_r.hi_t = '0;
            next_r.lo_t = '0;
         end else if (en_rise) begin
            next_r.lo_t = '0;
         end
         // end of stream: line held high past one bit's worth
         if (en_q && r.hi_t > 16'(STREAM_END_US) - 16'h0001 &&
             r.hi_t != '1 && r.tick) begin
            next_r.hi_t = '1;
            if (r.nbits == 5'(FRAME_W)) begin
               next_r.code = r.shreg[CODE_W-1:0]; // RULE15
               next_r.upd = 1'b1;
               if (r.shreg[ACK_BIT_POS]) begin // RULE13
                  next_r.ack = 1'b1;
                  next_r.ack_t = '0;
               end
            end
            next_r.nbits = '0;
         end
      end
      // acknowledge window, driven low from the next cycle
      if (r.ack && r.tick) begin
         next_r.ack_t = r.ack_t + 16'h0001;
         if (r.ack_t >= 16'(ACK_HOLD_US)) begin // RULE14
            next_r.ack = 1'b0;
         end
      end
      // shutdown path clears the whole sequence
      if (!sup_q || en_expired || dim_expired) begin // RULE7
         next_r.state = BSS_OFF; // RULE16
         next_r.one_wire = 1'b0; // RULE18
         next_r.ch_en = '0;
         next_r.ss_t = '0;
         next_r.ramp = '0;
         next_r.code = CODE_RESET; // RULE15
         next_r.ack = 1'b0;
         next_r.nbits = '0;
         next_r.hi_t = '0;
         next_r.lo_t = '0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
         r.code <= CODE_RESET;
         r.state <= BSS_OFF;
      end else begin
         r <= next_r;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign active_o = (r.state == BSS_RUN);
   assign one_wire_sel_o = r.one_wire;
   assign channel_en_o = r.ch_en;
   assign switching_o = (r.state == BSS_RUN); // RULE6
   assign startup_current_limit_o = (r.state == BSS_RUN) &&
                                    (r.ss_t < 16'(LIMIT_TICKS)); // RULE8
   assign comp_ramp_o = r.ramp;
   assign brightness_code_o = r.code;
   assign code_update_o = r.upd;
   // open drain: only ever pulls low
   assign enable_pin_ack_o = 1'b0;
   assign enable_pin_ack_oe_o = r.ack; // RULE13
   logic unused_ack;
   assign unused_ack = enable_pin_ack_i;
endmodule

// ===== verification/bss_seq_checker.sv
`timescale 1ns/1ps
module bss_seq_checker
   import bss_pkg::*;
#(
   parameter int LIMIT_TICKS = 5000,
   parameter int TICK_CYCLES = TICK_DIV
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic enable_pin_ack_o,
   input wire logic enable_pin_ack_oe_o,
   input wire logic active_o,
   input wire logic one_wire_sel_o,
   input wire logic [NCH-1:0] channel_en_o,
   input wire logic switching_o,
   input wire logic startup_current_limit_o,
   input wire logic [7:0] comp_ramp_o,
   input wire logic [CODE_W-1:0] brightness_code_o,
   input wire logic code_update_o
);
   // ------
   // helpers
   // ------
   // run lengths; cleared while low so a stuck output shows up
   logic [CNT_W+7:0] lim_cnt;
   logic [CNT_W+7:0] ack_cnt;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lim_cnt <= '0;
         ack_cnt <= '0;
      end else begin
         lim_cnt <= startup_current_limit_o ? lim_cnt + 1'b1 : '0;
         ack_cnt <= enable_pin_ack_oe_o ? ack_cnt + 1'b1 : '0;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   // ------
   // properties
   // ------
   property p_no_dead;
      switching_o |-> channel_en_o != '0;
   endproperty
   a_no_dead: assert property (p_no_dead)
      else $error("switching with no channel");
   property p_ramp;
      $rose(switching_o) |->
         comp_ramp_o == 8'h00 ##[0:2] startup_current_limit_o;
   endproperty
   a_ramp: assert property (p_ramp)
      else $error("soft start not from zero");
   property p_lim_run;
      startup_current_limit_o |-> switching_o;
   endproperty
   a_lim_run: assert property (p_lim_run)
      else $error("reduced limit outside run");
   property p_lim_len;
      $fell(startup_current_limit_o) && switching_o |->
         lim_cnt >= LIMIT_TICKS * TICK_CYCLES - 200 &&
         lim_cnt <= LIMIT_TICKS * TICK_CYCLES + 200;
   endproperty
   a_lim_len: assert property (p_lim_len)
      else $error("reduced limit window length wrong");
   property p_ack_sel;
      enable_pin_ack_oe_o |-> one_wire_sel_o && active_o;
   endproperty
   a_ack_sel: assert property (p_ack_sel)
      else $error("ack outside one-wire mode");
   property p_ack_low;
      enable_pin_ack_oe_o |-> !enable_pin_ack_o;
   endproperty
   a_ack_low: assert property (p_ack_low)
      else $error("ack not driven low");
   property p_ack_len;
      ack_cnt <= ACK_DURATION_US * TICK_CYCLES;
   endproperty
   a_ack_len: assert property (p_ack_len)
      else $error("ack held too long");
   property p_upd;
      code_update_o |=> !code_update_o;
   endproperty
   a_upd: assert property (p_upd)
      else $error("code update not a pulse");
   property p_off;
      $fell(active_o) |-> ##[0:2] (brightness_code_o == CODE_RESET &&
         channel_en_o == '0 && !one_wire_sel_o && !switching_o);
   endproperty
   a_off: assert property (p_off)
      else $error("state not cleared at shutdown");
endmodule

bind bss_sequencer bss_seq_checker #(
   .LIMIT_TICKS(LIMIT_TICKS),
   .TICK_CYCLES(TICK_CYCLES)
) chk (
   .clk_i(clk_i),
   .arst_n_i(arst_n_i),
   .enable_pin_ack_o(enable_pin_ack_o),
   .enable_pin_ack_oe_o(enable_pin_ack_oe_o),
   .active_o(active_o),
   .one_wire_sel_o(one_wire_sel_o),
   .channel_en_o(channel_en_o),
   .switching_o(switching_o),
   .startup_current_limit_o(startup_current_limit_o),
   .comp_ramp_o(comp_ramp_o),
   .brightness_code_o(brightness_code_o),
   .code_update_o(code_update_o)
);

// ===== verification/bss_host_model.sv
`timescale 1ns/1ps
// host gpio: open-drain enable line with pull-up, dimming pin
module bss_host_model #(
   parameter int TICK_CYCLES = bss_pkg::TICK_DIV
) (
   input wire logic clk_i,
   input wire logic dev_oe_i,
   output logic en_wire_o,
   output logic dim_o
);
   import bss_pkg::*;
   logic drive = 1'b0;
   initial dim_o = 1'b0;
   // pull-up unless either side pulls low
   assign en_wire_o = drive & ~dev_oe_i;
   task automatic hold_us(input int us);
      repeat (us * TICK_CYCLES) @(negedge clk_i);
   endtask
   task automatic level(input logic v, input int us);
      drive = v;
      hold_us(us);
   endtask
   task automatic dim(input logic v);
      dim_o = v;
   endtask
   // rise, wait past the delay, then a long low inside the window
   task automatic detect(input int low_us);
      level(1'b1, 150);
      level(1'b0, low_us);
      drive = 1'b1;
   endtask
   // msb first; long phase twice the short one
   task automatic frame(input logic [15:0] w, input int t);
      // idle high first, so any earlier stream is closed by the device
      level(1'b1, STREAM_END_US + 40);
      level(1'b0, 4);
      for (int i = 15; i >= 0; i--) begin
         level(1'b1, w[i] ? 2 * t : t);
         level(1'b0, w[i] ? t : 2 * t);
      end
      drive = 1'b1;
   endtask
endmodule

// ===== verification/backlight_startup_sequencer_tb.sv
`timescale 1ns/1ps
module backlight_startup_sequencer_tb;
   import bss_pkg::*;
   localparam int EN_OFF = 400;
   localparam int DIM_OFF = 200;
   localparam int LIM = 50;
   localparam int TICK = 10;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic supply_good_i = 1'b0;
   logic [NCH-1:0] sink_feedback_pin_i = '1;
   logic enable_pin_i, dimming_pin_i, enable_pin_ack_i;
   logic enable_pin_ack_o, enable_pin_ack_oe_o, active_o;
   logic one_wire_sel_o, switching_o, startup_current_limit_o;
   logic code_update_o, act_d;
   logic [NCH-1:0] channel_en_o;
   logic [7:0] comp_ramp_o;
   logic [CODE_W-1:0] brightness_code_o, r;
   logic [2:0] start_q[$];
   logic [CODE_W-1:0] code_q[$];
   int num_errors = 0;
   int check_count = 0;
   int cycles = 0;
   int oe_len = 0;
   int oe_was;
   always #5 clk_i = ~clk_i;
   assign enable_pin_ack_i = enable_pin_i;
   bss_sequencer #(
      .EN_OFF_TICKS(EN_OFF),
      .DIM_OFF_TICKS(DIM_OFF),
      .LIMIT_TICKS(LIM),
      .TICK_CYCLES(TICK)
   ) uut (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .supply_good_i(supply_good_i),
      .enable_pin_i(enable_pin_i),
      .dimming_pin_i(dimming_pin_i),
      .sink_feedback_pin_i(sink_feedback_pin_i),
      .enable_pin_ack_i(enable_pin_ack_i),
      .enable_pin_ack_o(enable_pin_ack_o),
      .enable_pin_ack_oe_o(enable_pin_ack_oe_o),
      .active_o(active_o),
      .one_wire_sel_o(one_wire_sel_o),
      .channel_en_o(channel_en_o),
      .switching_o(switching_o),
      .startup_current_limit_o(startup_current_limit_o),
      .comp_ramp_o(comp_ramp_o),
      .brightness_code_o(brightness_code_o),
      .code_update_o(code_update_o)
   );
   bss_host_model #(.TICK_CYCLES(TICK)) host (.clk_i(clk_i),
      .dev_oe_i(enable_pin_ack_oe_o),
      .en_wire_o(enable_pin_i), .dim_o(dimming_pin_i));
   // ------
   // reporting
   // ------
   task automatic check(string n, logic [15:0] e, logic [15:0] g);
      check_count++;
      if (e !== g) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // monitor at negedge, where outputs have settled
   always @(negedge clk_i) begin
      cycles++;
      // about 70k cycles expected; the ceiling catches a hang
      if (cycles > 100000) begin
         num_errors++;
         complete_run();
      end
      if (enable_pin_ack_oe_o === 1'b1)
         oe_len++;
      if (active_o === 1'b1 && act_d !== 1'b1)
         check("start", start_q.size() ? start_q.pop_front() : 3'h7,
            {one_wire_sel_o, channel_en_o});
      if (code_update_o === 1'b1)
         check("code", code_q.size() ? code_q.pop_front() : 9'h0,
            brightness_code_o);
      act_d = active_o;
   end
   // shutdown leaves active and selection cleared, code at all ones
   task automatic check_off();
      check("active", 0, active_o);
      check("cleared", {1'b0, CODE_RESET}, {one_wire_sel_o,
         brightness_code_o});
   endtask
   initial begin
      void'($urandom(32'h60e56eae));
      repeat (5) @(negedge clk_i);
      arst_n_i = 1'b1;
      supply_good_i = 1'b1;
      host.dim(1'b1);
      // both sinks grounded: never switch
      sink_feedback_pin_i = 2'b00;
      host.level(1'b1, 1100);
      check("abort", 0, {active_o, switching_o});
      host.level(1'b0, EN_OFF + 20);
      // pwm interface, random channel mask with at most one sink grounded
      sink_feedback_pin_i = NCH'($urandom_range(1, 3));
      start_q.push_back({1'b0, sink_feedback_pin_i});
      host.level(1'b1, 1100 + LIM + 20);
      check("limit_end", 1, {startup_current_limit_o, switching_o});
      check("ramp", 1, comp_ramp_o > 8'h1e && comp_ramp_o < 8'h32);
      host.dim(1'b0);
      host.hold_us(DIM_OFF + 20);
      check_off();
      host.level(1'b0, 10);
      host.dim(1'b1);
      // one-wire interface, both channels
      sink_feedback_pin_i = 2'b11;
      start_q.push_back(3'b111);
      host.detect(280);
      host.hold_us(700);
      code_q.push_back(9'h0a5);
      host.frame(16'h80a5, 4);
      host.hold_us(700);
      check("ack", 1, oe_len > 0 &&
         oe_len <= ACK_DURATION_US * TICK);
      oe_was = oe_len;
      r = CODE_W'($urandom);
      code_q.push_back(r);
      host.frame({7'h00, r}, 3);
      host.hold_us(700);
      check("no_ack", oe_was, oe_len);
      // supply loss mid-run shuts down and restores the default code
      supply_good_i = 1'b0;
      host.hold_us(5);
      check_off();
      supply_good_i = 1'b1;
      host.level(1'b0, EN_OFF + 20);
      check_off();
      check("left", 0, start_q.size() + code_q.size());
      complete_run();
   end
endmodule
